// *** src/dmr_pkg.sv ***
// Package of constants for the DDR2 mode-register capture block
package dmr_pkg;
	// Bank selectors for mode writes
	localparam logic [2:0] BA_MAIN = 3'h0;
	localparam logic [2:0] BA_EXT1 = 3'h1;
	localparam logic [2:0] BA_EXT2 = 3'h2;
	localparam logic [2:0] BA_EXT3 = 3'h3;
	// Main register field positions
	localparam int MR_BL_LO = 0;
	localparam int MR_BT = 3;
	localparam int MR_CL_LO = 4;
	localparam int MR_TM = 7;
	localparam int MR_DLLRST = 8;
	localparam int MR_WR_LO = 9;
	// Extended register one field positions
	localparam int E1_DLLDIS = 0;
	localparam int E1_RDS = 1;
	localparam int E1_RTT0 = 2;
	localparam int E1_AL_LO = 3;
	localparam int E1_RTT1 = 6;
	localparam int E1_CAL_LO = 7;
	localparam int E1_STRDIS = 10;
	localparam int E1_RSVD = 11;
	// Burst length codes
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	// Calibration control codes
	localparam logic [2:0] CAL_EXIT = 3'h0;
	localparam logic [2:0] CAL_DEFAULT = 3'h7;
	// DLL lock time in link clocks
	localparam int DLL_LOCK_CLK = 200;
	localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLK);
	// Software register byte offsets
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_EXT1 = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0C;
endpackage

// *** src/dmr_burst_order.sv ***
// Burst column order generator
`timescale 1ns/1ps
module dmr_burst_order (
	input wire logic [2:0] start_col,
	input wire logic interleave,
	input wire logic [2:0] beat,
	output logic [2:0] col
);
	// Sequential wraps in group of four; interleave XORs the beat
	always_comb begin
		if (interleave) begin
			col = start_col ^ beat;
		end else begin
			col = {start_col[2] ^ beat[2], 2'(start_col[1:0] + beat[1:0])};
		end
	end
endmodule

// *** src/dmr_top.sv ***
// Device-side command decoder holding main and extended register one
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module dmr_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	input wire logic [2:0] burst_start,
	input wire logic [2:0] burst_beat,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic [2:0] burst_col,
	output logic dll_locked,
	output logic strobe_comp_en
);
	////////////////////////////////////////////////////////////////////
	// Input synchronisers, two flops each
	logic [24:0] s1_r;
	logic [24:0] s2_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {link_clk, cke, cs_n, ras_n, cas_n, we_n, ba, addr};
			s2_r <= s1_r;
		end
	end
	logic lclk_q;
	logic cke_q;
	logic [3:0] cmd_q;
	logic [2:0] ba_q;
	logic [15:0] addr_q;
	assign {lclk_q, cke_q, cmd_q, ba_q, addr_q} = s2_r;

	// Edge finder and previous CKE sample
	logic lclk_d_r;
	logic cke_prev_r;
	logic rise;
	assign rise = lclk_q & ~lclk_d_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lclk_d_r <= 1'b0;
			cke_prev_r <= 1'b0;
		end else begin
			lclk_d_r <= lclk_q;
			if (rise) begin
				cke_prev_r <= cke_q;
			end
		end
	end

	// Mode write: all strobes low, CKE high now and before
	logic mode_wr;
	assign mode_wr = rise & cke_q & cke_prev_r & (cmd_q == 4'h0);

	////////////////////////////////////////////////////////////////////
	// Mode registers, undefined until written (reset to zero here)
	logic [12:0] main_r;
	logic [12:0] ext1_r;
	logic main_valid_r;
	logic ext1_valid_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			main_r <= '0;
			ext1_r <= '0;
			main_valid_r <= 1'b0;
			ext1_valid_r <= 1'b0;
		end else if (mode_wr) begin
			case (ba_q)
				dmr_pkg::BA_MAIN: begin
					main_r <= addr_q[12:0];
					main_valid_r <= 1'b1;
				end
				dmr_pkg::BA_EXT1: begin
					ext1_r <= addr_q[12:0];
					ext1_valid_r <= 1'b1;
				end
				// Registers two and three: accepted, fields not kept
				dmr_pkg::BA_EXT2, dmr_pkg::BA_EXT3: ;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Field decode
	logic [2:0] bl_f;
	logic bt_f;
	logic [2:0] cl_f;
	logic [2:0] wr_f;
	logic [2:0] al_f;
	logic [2:0] cal_f;
	logic dll_dis_f;
	assign bl_f = main_r[dmr_pkg::MR_BL_LO +: 3];
	assign bt_f = main_r[dmr_pkg::MR_BT];
	assign cl_f = main_r[dmr_pkg::MR_CL_LO +: 3];
	assign wr_f = main_r[dmr_pkg::MR_WR_LO +: 3];
	assign al_f = ext1_r[dmr_pkg::E1_AL_LO +: 3];
	assign cal_f = ext1_r[dmr_pkg::E1_CAL_LO +: 3];
	assign dll_dis_f = ext1_r[dmr_pkg::E1_DLLDIS];

	// Event: DLL enable or DLL reset both restart locking
	logic dll_restart;
	assign dll_restart = mode_wr & (
		((ba_q == dmr_pkg::BA_EXT1) & ~addr_q[dmr_pkg::E1_DLLDIS]) |
		((ba_q == dmr_pkg::BA_MAIN) & addr_q[dmr_pkg::MR_DLLRST]));

	////////////////////////////////////////////////////////////////////
	// DLL lock counter in link clocks
	logic [7:0] lock_cnt_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_cnt_r <= '0;
			dll_locked <= 1'b0;
		end else if (dll_restart) begin
			lock_cnt_r <= dmr_pkg::DLL_LOCK_CNT;
			dll_locked <= 1'b0;
		end else if (rise && lock_cnt_r != 8'h00) begin
			lock_cnt_r <= 8'(lock_cnt_r - 8'h01);
		end else begin
			dll_locked <= (lock_cnt_r == 8'h00) & ext1_valid_r & ~dll_dis_f;
		end
	end

	// Complementary strobe only when not disabled
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_comp_en <= 1'b0;
		end else begin
			strobe_comp_en <= ext1_valid_r & ~ext1_r[dmr_pkg::E1_STRDIS];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Burst order, registered
	logic [2:0] col_c;
	dmr_burst_order u_order (
		.start_col(bl_f == dmr_pkg::BL_FOUR ? {1'b0, burst_start[1:0]}
			: burst_start),
		.interleave(bt_f),
		.beat(bl_f == dmr_pkg::BL_FOUR ? {1'b0, burst_beat[1:0]}
			: burst_beat),
		.col(col_c)
	);
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			burst_col <= '0;
		end else begin
			burst_col <= col_c;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Software control: sticky error clear
	logic err_r;
	logic err_set;
	// Reserved field misuse: test mode, nonzero write recovery, A11
	assign err_set = mode_wr & (
		((ba_q == dmr_pkg::BA_MAIN) & (addr_q[dmr_pkg::MR_TM] |
		(addr_q[dmr_pkg::MR_WR_LO +: 3] != 3'h0) | (addr_q[15:13] != 3'h0)))
		| ((ba_q == dmr_pkg::BA_EXT1)
		& addr_q[dmr_pkg::E1_RSVD]));

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	logic aw_got_r;
	logic w_got_r;
	logic [7:0] awa_r;
	logic [31:0] wd_r;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awa_r <= '0;
			wd_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			s_axi_awready <= ~aw_got_r & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~w_got_r & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awa_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wd_r <= s_axi_wdata;
			end
			if (aw_got_r && w_got_r && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awa_r == dmr_pkg::OFS_CTRL) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
		end
	end

	// Error flag: set wins over write-one-to-clear
	logic wr_clr;
	assign wr_clr = aw_got_r & w_got_r & ~s_axi_bvalid
		& (awa_r == dmr_pkg::OFS_CTRL) & wd_r[0];
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			err_r <= 1'b0;
		end else if (err_set) begin
			err_r <= 1'b1;
		end else if (wr_clr) begin
			err_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	logic [31:0] rd_c;
	always_comb begin
		rd_c = 32'h0000_0000;
		// Only the low window decodes; anything above reads zero
		if (s_axi_araddr[31:8] == 24'h00_0000) begin
			case (s_axi_araddr[7:0])
				dmr_pkg::OFS_MAIN: rd_c = {19'h0, main_r};
				dmr_pkg::OFS_EXT1: rd_c = {19'h0, ext1_r};
				dmr_pkg::OFS_STAT: rd_c = {20'h0, cl_f, al_f, 2'h0, err_r,
					dll_locked, ext1_valid_r, main_valid_r};
				dmr_pkg::OFS_CTRL: rd_c = {16'h0, 1'b0, wr_f, cal_f, 6'h0,
					err_r, 2'h0};
				default: rd_c = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_c;
				s_axi_rresp <= (s_axi_araddr > {24'h00_0000,
					dmr_pkg::OFS_CTRL}) ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** testbench/dmr_monitor.sv ***
// Port checker for the mode-register block
`timescale 1ns/1ps
module dmr_monitor (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	input wire logic [2:0] burst_start,
	input wire logic [2:0] burst_beat,
	input wire logic [2:0] burst_col,
	input wire logic dll_locked,
	input wire logic strobe_comp_en,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic lk_r; // Link clock one cycle back
	// Delayed link clock to find its rises
	always_ff @(posedge ref_clk) begin
		lk_r <= link_clk;
	end
	// Mode write on the raw pins at a link rise
	wire mw = link_clk & ~lk_r & cke & ~(cs_n | ras_n | cas_n | we_n);
	wire [1:0] seq_lo = burst_start[1:0] + burst_beat[1:0]; // Wrapped sum
	sequence e1_wr;
		mw && ba == dmr_pkg::BA_EXT1;
	endsequence
	a_col_wrap: assert property (
		1 |=> (burst_col[1:0] == $past(seq_lo)
		|| burst_col[1:0] == $past(burst_start[1:0] ^ burst_beat[1:0])))
		else $error("burst column off");
	a_lock_drop: assert property (
		e1_wr |-> ##[1:7] !dll_locked [*8]) else $error("lock kept");
	a_dll_reset: assert property (
		mw && ba == dmr_pkg::BA_MAIN && addr[8] |-> ##[1:7] !dll_locked)
		else $error("lock kept after DLL reset");
	a_strobe_set: assert property (
		e1_wr |-> ##[2:7] strobe_comp_en == !addr[10])
		else $error("strobe enable wrong");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read ready held");
	a_bad_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h0000_000C
		|=> s_axi_rvalid && s_axi_rresp == 2'b10) else $error("bad read");
endmodule
bind dmr_top dmr_monitor mon (.ref_clk, .sys_rst, .link_clk, .cke, .cs_n,
	.ras_n, .cas_n, .we_n, .ba, .addr, .burst_start, .burst_beat, .burst_col,
	.dll_locked, .strobe_comp_en, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp);

// *** testbench/dmr_ctrl_model.sv ***
// Memory controller model: link clock and command bus
`timescale 1ns/1ps
module dmr_ctrl_model (
	output logic link_clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] ba,
	output logic [15:0] addr
);
	// Free-running link clock, phase apart from the system clock
	initial begin
		link_clk = 1'b0;
		#3;
		forever #40 link_clk = ~link_clk;
	end
	// Power-up: clock enable low, bus idle
	initial begin
		cke = 1'b0;
		{cs_n, ras_n, cas_n, we_n} = 4'h7;
		ba = 3'h0;
		addr = 16'h0000;
	end
	// One command for one link cycle, then NOP with scrambled address
	task automatic cmd(input logic [3:0] c, input logic [2:0] b,
		input logic [15:0] a);
		@(negedge link_clk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		@(negedge link_clk);
		{cs_n, ras_n, cas_n, we_n} <= 4'h7;
		ba <= ~b;
		addr <= ~a;
		repeat (2) @(negedge link_clk);
	endtask
	// Start-up order with short stand-in waits
	task automatic init();
		repeat (4) @(negedge link_clk);
		cke <= 1'b1;
		repeat (5) @(negedge link_clk);
		cmd(4'h2, 3'h0, 16'h0400);
		cmd(4'h0, dmr_pkg::BA_EXT2, 16'h0000);
		cmd(4'h0, dmr_pkg::BA_EXT3, 16'h0000);
		cmd(4'h0, dmr_pkg::BA_EXT1, 16'h0010);
		cmd(4'h0, dmr_pkg::BA_MAIN, 16'h0153);
		cmd(4'h2, 3'h0, 16'h0400);
		cmd(4'h1, 3'h0, 16'h0000);
		cmd(4'h1, 3'h0, 16'h0000);
		cmd(4'h0, dmr_pkg::BA_MAIN, 16'h0053);
		repeat (200) @(negedge link_clk);
		cmd(4'h0, dmr_pkg::BA_EXT1, 16'h0390);
		cmd(4'h0, dmr_pkg::BA_EXT1, 16'h0010);
	endtask
endmodule

// *** testbench/tb_ddr_init_mode_registers.sv ***
// Self-checking bench for the mode-register block
`timescale 1ns/1ps
module tb_ddr_init_mode_registers;
	logic ref_clk, sys_rst, link_clk, cke, cs_n, ras_n, cas_n, we_n;
	logic [2:0] ba, burst_start, burst_beat, burst_col;
	logic [15:0] addr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, dll_locked, strobe_comp_en;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total = 0, tests_run = 0, cyc = 0;
	dmr_top uut (.*);
	dmr_ctrl_model ctl (.*);
	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Register write, response code checked
	task automatic axw(input logic [31:0] a, d, input logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	// Register read into rd, response code checked
	task automatic axr(input logic [31:0] a, input logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		chk(s_axi_rresp, r);
	endtask
	// Start-up, lock wait, readback
	task automatic t_init();
		chk(dll_locked, 0);
		ctl.init();
		chk(dll_locked, 0);
		repeat (210) @(posedge link_clk);
		axr(32'h0000_0000, 2'h0);
		chk(rd, 32'h0000_0053);
		axr(32'h0000_0004, 2'h0);
		chk(rd, 32'h0000_0010);
		axr(32'h0000_0008, 2'h0);
		chk(rd, 32'h0000_0A87);
		chk({dll_locked, strobe_comp_en}, 2'h3);
	endtask
	// Both burst types at both lengths, every start and beat
	task automatic t_order();
		logic [2:0] e;
		for (int m = 0; m < 4; m++) begin
			ctl.cmd(4'h0, dmr_pkg::BA_MAIN, {9'h000, 3'h5, m[0],
				m[1] ? dmr_pkg::BL_EIGHT : dmr_pkg::BL_FOUR});
			for (int i = 0; i < 64; i++) begin
				@(posedge ref_clk);
				burst_start <= i[5:3];
				burst_beat <= i[2:0];
				// Group bit flips per four beats; low bits wrap in group
				e = m[0] ? i[5:3] ^ i[2:0] : (((i[5:3] ^ i[2:0]) & 3'h4)
					| 3'((i[5:3] + i[2:0]) & 3'h3));
				repeat (2) @(posedge ref_clk);
				chk(burst_col, e & (m[1] ? 3'h7 : 3'h3));
			end
		end
	endtask
	// Disable, re-enable with single strobe, relock, DLL reset
	task automatic t_dll();
		ctl.cmd(4'h0, dmr_pkg::BA_EXT1, 16'h0011);
		chk(dll_locked, 0);
		ctl.cmd(4'h0, dmr_pkg::BA_EXT1, 16'h0410);
		chk(strobe_comp_en, 0);
		repeat (190) @(posedge link_clk);
		chk(dll_locked, 0);
		repeat (15) @(posedge link_clk);
		chk(dll_locked, 1);
		ctl.cmd(4'h0, dmr_pkg::BA_MAIN, 16'h0153);
		chk(dll_locked, 0);
	endtask
	// Test-mode flag, clear, refused accesses
	task automatic t_err();
		ctl.cmd(4'h0, dmr_pkg::BA_MAIN, 16'h00D3);
		axr(32'h0000_0008, 2'h0);
		chk(rd[3], 1);
		axw(32'h0000_000C, 32'h0000_0001, 2'h0);
		axr(32'h0000_0008, 2'h0);
		chk(rd[3], 0);
		axw(32'h0000_0000, 32'h0000_0001, 2'h2);
		axr(32'h0000_0010, 2'h2);
		chk(rd, 0);
	endtask
	// Verdict and end of run
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// System clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			print_verdict();
		end
	end
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, burst_start, burst_beat} = 8'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_init();
		t_order();
		t_dll();
		t_err();
		print_verdict();
	end
endmodule
